/* rtl/charge_limit_bank.sv */
/*
  Charge voltage limit register with the charge current setting it steers,
  reached by command code from the SMBus command decoder.
  Assumes the decoder runs on clock and gives whole 16-bit words; the
  strap and power good inputs come from pins and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "charge_limit_params.svh"
// Overview of operation
// - One 16-bit word at command 0x15
// - Bits 14:4 voltage code, 16 mV LSB
// - Reject nonzero writes outside 1.024-19.200 V
// - Power-on default from cell count strap
// - Stored value is system regulation target
// - Zero write restores default, clears current
// - Current write after power good starts charging
// - Bit 15 set makes write invalid
// - Bits 3:0 dropped from a stored word
// - Current setting resets to zero, no charge
module charge_limit_bank (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // Pins from outside the clock domain
  input wire logic [1:0] cell_count_config_pin,
  input wire logic input_power_good,
  // Host register port
  input wire logic [7:0] cmd_code,
  input wire logic wr_strobe,
  input wire logic [15:0] wr_data,
  input wire logic rd_strobe,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic wr_busy,
  // Toward the regulation loop
  output logic [15:0] charge_voltage_limit,
  output logic [15:0] charge_voltage_command,
  output logic [15:0] charge_current_setting,
  output logic charge_enable
);
  import charge_limit_pkg::*;

  bank_state_t s_r;    // Registered state
  bank_state_t s_nxt;  // Next state
  logic wr_v;          // Write to the voltage word
  logic wr_c;          // Write to the current word

  write_check_if chk_bus ();

  // Word classifier
  write_check u_check (
    .chk(chk_bus)
  );

  assign chk_bus.wdata = wr_data;
  assign chk_bus.cells = s_r.cell_s2_r;

  // Writes are taken only after the strap default is in
  assign wr_v = wr_strobe && s_r.boot_done_r && (cmd_code == `CMD_CHARGE_VOLTAGE);
  assign wr_c = wr_strobe && s_r.boot_done_r && (cmd_code == `CMD_CHARGE_CURRENT);

  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd_valid_r = 1'b0;
    // Pin synchronisers
    s_nxt.cell_s1_r = cell_count_config_pin;
    s_nxt.cell_s2_r = s_r.cell_s1_r;
    s_nxt.pg_s1_r = input_power_good;
    s_nxt.pg_s2_r = s_r.pg_s1_r;
    // Start-up: wait for the strap to settle, then load its default
    if (!s_r.boot_done_r) begin
      if (s_r.boot_cnt_r == `BOOT_CYCLES) begin
        s_nxt.boot_done_r = 1'b1;
        s_nxt.cvl_r = chk_bus.v_default;
      end else begin
        s_nxt.boot_cnt_r = s_r.boot_cnt_r + 2'h1;
      end
    end
    // Voltage word write
    if (wr_v) begin
      if (chk_bus.v_zero) begin
        s_nxt.cvl_r = chk_bus.v_default;
        s_nxt.ccs_r = 16'h0000;
      end else if (chk_bus.v_accept) begin
        s_nxt.cvl_r = {1'b0, wr_data[`CVL_CODE_MSB:`CVL_CODE_LSB], 4'h0};
      end
      // Otherwise the word is dropped and the old value stays
    end
    // Current word write, ignored reserved low bits cleared
    if (wr_c && chk_bus.c_accept) begin
      s_nxt.ccs_r = {3'h0, wr_data[`CCS_CODE_MSB:`CCS_CODE_LSB], 6'h00};
    end
    // Power lost clears the current setting
    if (!s_r.pg_s2_r) begin
      s_nxt.ccs_r = 16'h0000;
    end
    // Charging follows the current setting while power is good
    s_nxt.charge_en_r = s_r.pg_s2_r && (s_nxt.ccs_r != 16'h0000);
    // Read answer, one cycle after the strobe
    if (rd_strobe) begin
      if (cmd_code == `CMD_CHARGE_VOLTAGE) begin
        s_nxt.rd_valid_r = 1'b1;
        s_nxt.rd_data_r = s_r.cvl_r;
      end else if (cmd_code == `CMD_CHARGE_CURRENT) begin
        s_nxt.rd_valid_r = 1'b1;
        s_nxt.rd_data_r = s_r.ccs_r;
      end
    end
  end

  // State register, frozen while the enable is low except for reset, which loads whatever the enable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= '{cell_s1_r: 2'h0, cell_s2_r: 2'h0, pg_s1_r: 1'b0, pg_s2_r: 1'b0, boot_cnt_r: 2'h0,
        boot_done_r: 1'b0, cvl_r: `CVL_RESET, ccs_r: `CCS_RESET, rd_data_r: 16'h0000,
        rd_valid_r: 1'b0, charge_en_r: 1'b0};
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign rd_data = s_r.rd_data_r;
  assign rd_valid = s_r.rd_valid_r;
  assign wr_busy = !s_r.boot_done_r;
  assign charge_voltage_limit = s_r.cvl_r;
  assign charge_voltage_command = s_r.cvl_r;
  assign charge_current_setting = s_r.ccs_r;
  assign charge_enable = s_r.charge_en_r;

  // Checks
  sequence seq_v_write_bad;
    wr_v && clk_en && !chk_bus.v_zero && !chk_bus.v_accept;
  endsequence

  sequence seq_v_write_zero;
    wr_v && clk_en && chk_bus.v_zero;
  endsequence

  sequence seq_cc_start;
    wr_c && clk_en && chk_bus.c_accept && s_r.pg_s2_r && (wr_data[12:6] != 7'h00);
  endsequence

  // Out-of-range voltage word leaves the stored word alone
  chk_range_reject: assert property (@(posedge clock) disable iff (!rst_n)
    seq_v_write_bad |=> $stable(s_r.cvl_r))
    else $error("rejected voltage write changed the word");

  // Reserved top bit set refuses the word
  chk_bit15_invalid: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_v && clk_en && wr_data[15]) |=> (s_r.cvl_r == $past(s_r.cvl_r)))
    else $error("write with bit 15 set was applied");

  // Accepted code lands in bits 14:4
  chk_accept_store: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_v && clk_en && chk_bus.v_accept) |=> (s_r.cvl_r[14:4] == $past(wr_data[14:4])))
    else $error("accepted voltage code not stored");

  // Reserved bits of the stored word stay zero
  chk_low_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    s_r.boot_done_r |-> (s_r.cvl_r[3:0] == 4'h0) && !s_r.cvl_r[15])
    else $error("reserved bits of the voltage word not zero");

  // Zero write reloads the default and stops charging
  chk_zero_restore: assert property (@(posedge clock) disable iff (!rst_n)
    seq_v_write_zero |=> (s_r.cvl_r == $past(chk_bus.v_default)) && (s_r.ccs_r == 16'h0000) && !charge_enable)
    else $error("zero write did not restore default and stop charge");

  // Strap default is loaded when the start-up wait ends
  chk_boot_default: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && !s_r.boot_done_r && s_r.boot_cnt_r == `BOOT_CYCLES) |=> s_r.boot_done_r &&
      (s_r.cvl_r == $past(chk_bus.v_default)))
    else $error("strap default not loaded at start-up");

  // Valid current write with power good starts charging
  chk_charge_start: assert property (@(posedge clock) disable iff (!rst_n)
    seq_cc_start ##1 s_r.pg_s2_r |-> charge_enable)
    else $error("charging did not start after current write");

  // Reset leaves the current word at zero
  chk_cc_reset: assert property (@(posedge clock)
    !$past(rst_n) |-> (s_r.ccs_r == 16'h0000) && !charge_enable)
    else $error("current setting not zero after reset");

  // Voltage read answers the stored word next cycle
  chk_read_back: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_strobe && clk_en && cmd_code == `CMD_CHARGE_VOLTAGE) |=> rd_valid && (rd_data == $past(s_r.cvl_r)))
    else $error("voltage read did not return stored word");

  // Target output follows each accepted voltage word
  chk_target_follow: assert property (@(posedge clock) disable iff (!rst_n)
    (wr_v && clk_en && chk_bus.v_accept) |=> (charge_voltage_limit == charge_voltage_command) &&
      (charge_voltage_command == {1'b0, $past(wr_data[14:4]), 4'h0}))
    else $error("regulation target does not follow the stored word");

  // Any write before the default is in, outside the load cycle itself
  sequence seq_boot_write;
    wr_strobe && clk_en && !s_r.boot_done_r && (s_r.boot_cnt_r != `BOOT_CYCLES);
  endsequence

  // Writes during start-up are dropped
  chk_busy_drop: assert property (@(posedge clock) disable iff (!rst_n)
    seq_boot_write |=> $stable(s_r.cvl_r) && $stable(s_r.ccs_r))
    else $error("write taken before the strap default was loaded");

  // A zero current word never lets charging run
  chk_zero_no_charge: assert property (@(posedge clock) disable iff (!rst_n)
    (s_r.ccs_r == 16'h0000) |-> !charge_enable)
    else $error("charging with a zero current setting");

  // Losing power good clears the current word
  chk_power_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && !s_r.pg_s2_r) |=> (s_r.ccs_r == 16'h0000) && !charge_enable)
    else $error("current setting kept without power good");

  // Commands other than the two words give no read answer
  chk_unknown_silent: assert property (@(posedge clock) disable iff (!rst_n)
    (rd_strobe && clk_en && (cmd_code != `CMD_CHARGE_VOLTAGE) && (cmd_code != `CMD_CHARGE_CURRENT)) |=>
      !rd_valid)
    else $error("read answered for an unknown command");
endmodule
`default_nettype wire

/* rtl/charge_limit_params.svh */
/*
  Constants of the charge voltage limit block: command codes, field positions,
  range limits, power-on defaults and start-up timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef CHARGE_LIMIT_PARAMS_SVH
`define CHARGE_LIMIT_PARAMS_SVH

// Command codes on the host register port
`define CMD_CHARGE_CURRENT 8'h14
`define CMD_CHARGE_VOLTAGE 8'h15

// Charge voltage limit word layout
`define CVL_RSVD_HI_BIT 15
`define CVL_CODE_MSB 14
`define CVL_CODE_LSB 4
`define CVL_CODE_W 11

// Charge current setting word layout
`define CCS_RSVD_MSB 15
`define CCS_RSVD_LSB 13
`define CCS_CODE_MSB 12
`define CCS_CODE_LSB 6

// Voltage code weight and accepted range, in millivolts
`define CVL_LSB_MV 16
`define CVL_MIN_MV 1024
`define CVL_MAX_MV 19200

// Power-on defaults per cell count, in millivolts
`define CVL_DEF_1S_MV 4192
`define CVL_DEF_2S_MV 8400
`define CVL_DEF_3S_MV 12592
`define CVL_DEF_4S_MV 16800

// Reset values of the two words
`define CCS_RESET 16'h0000
`define CVL_RESET 16'h0000

// Enabled cycles after reset release before the strap is taken
`define BOOT_CYCLES 2'h2

`endif

/* rtl/charge_limit_pkg.sv */
/*
  Types of the charge voltage limit block: the state record of the top module.
  Assumes the constants header is on the include path.
*/
`default_nettype none
package charge_limit_pkg;
  `include "charge_limit_params.svh"

  // Whole state of the register bank
  typedef struct packed {
    logic [1:0] cell_s1_r;   // Strap synchroniser, first stage
    logic [1:0] cell_s2_r;   // Strap synchroniser, second stage
    logic pg_s1_r;           // Power good synchroniser, first stage
    logic pg_s2_r;           // Power good synchroniser, second stage
    logic [1:0] boot_cnt_r;  // Start-up wait counter
    logic boot_done_r;       // Strap default taken, writes open
    logic [15:0] cvl_r;      // Charge voltage limit word
    logic [15:0] ccs_r;      // Charge current setting word
    logic [15:0] rd_data_r;  // Read answer
    logic rd_valid_r;        // Read answer strobe
    logic charge_en_r;       // Charging allowed
  } bank_state_t;
endpackage
`default_nettype wire

/* rtl/write_check_if.sv */
/*
  Carrier between the register bank and its write checker.
  Assumes one clock domain; the signals are purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface write_check_if;
  logic [15:0] wdata;       // Word offered by the host
  logic [1:0] cells;        // Synchronised cell count code
  logic v_accept;           // Word is a valid in-range voltage
  logic v_zero;             // Word is zero: restore default
  logic [15:0] v_default;   // Default word for the cell count
  logic c_accept;           // Word is a valid current setting

  modport checker_side (input wdata, input cells, output v_accept, output v_zero, output v_default,
    output c_accept);
  modport bank_side (output wdata, output cells, input v_accept, input v_zero, input v_default,
    input c_accept);
endinterface
`default_nettype wire

/* rtl/write_check.sv */
/*
  Write checker: classifies a host word for the voltage and current words
  and gives the cell-count default.
  Assumes wdata and cells are stable in the cycle of the write strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "charge_limit_params.svh"
module write_check (
  // Link to the bank
  write_check_if.checker_side chk
);
  import charge_limit_pkg::*;

  // Range ends as voltage codes
  localparam logic [10:0] CODE_MIN = 11'(`CVL_MIN_MV / `CVL_LSB_MV);
  localparam logic [10:0] CODE_MAX = 11'(`CVL_MAX_MV / `CVL_LSB_MV);

  logic [10:0] code;

  // Voltage code field, reserved low nibble dropped
  assign code = chk.wdata[`CVL_CODE_MSB:`CVL_CODE_LSB];

  // Zero word means reload the default
  assign chk.v_zero = (chk.wdata == 16'h0000);

  // In range, bit 15 clear
  assign chk.v_accept = !chk.wdata[`CVL_RSVD_HI_BIT] && (code >= CODE_MIN) && (code <= CODE_MAX);

  // Current word valid when its reserved top bits are clear
  assign chk.c_accept = (chk.wdata[`CCS_RSVD_MSB:`CCS_RSVD_LSB] == 3'h0);

  // Default word by cell count
  always_comb begin
    unique case (chk.cells)
      2'h0: chk.v_default = 16'(`CVL_DEF_1S_MV / `CVL_LSB_MV) << `CVL_CODE_LSB;
      2'h1: chk.v_default = 16'(`CVL_DEF_2S_MV / `CVL_LSB_MV) << `CVL_CODE_LSB;
      2'h2: chk.v_default = 16'(`CVL_DEF_3S_MV / `CVL_LSB_MV) << `CVL_CODE_LSB;
      2'h3: chk.v_default = 16'(`CVL_DEF_4S_MV / `CVL_LSB_MV) << `CVL_CODE_LSB;
    endcase
  end
endmodule
`default_nettype wire

/* verif/host_model.sv */
/* Host stand-in driving the bank's command port one whole word at a time.
   Assumes the bench calls its tasks; signals change on the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Command port toward the bank
  output logic [7:0] cmd_code,
  output logic wr_strobe,
  output logic [15:0] wr_data,
  output logic rd_strobe,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  // Idle port at time zero
  initial begin
    cmd_code = 8'h00;
    wr_strobe = 1'b0;
    wr_data = 16'h0000;
    rd_strobe = 1'b0;
  end
  // Write a full word; released data shows its inverse so stale values never pass
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clock);
    cmd_code = cmd;
    wr_data = data;
    wr_strobe = 1'b1;
    @(negedge clock);
    wr_strobe = 1'b0;
    wr_data = ~data;
  endtask
  // Read; the one-cycle answer strobe is taken in the cycle after the request
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
    @(negedge clock);
    cmd_code = cmd;
    rd_strobe = 1'b1;
    @(negedge clock);
    rd_strobe = 1'b0;
    ok = rd_valid;
    data = rd_data;
  endtask
  // Voltage word always goes ahead of the current word
  task automatic setup(input logic [15:0] volt, input logic [15:0] curr);
    wr(8'h15, volt);
    wr(8'h14, curr);
  endtask
endmodule
`default_nettype wire

/* verif/tb_charge_limit_bank.sv */
/* Self-checking bench for the charge voltage limit bank.
   Assumes the constants header on the include path and the host model. */
`timescale 1ns/1ps
`default_nettype none
`include "charge_limit_params.svh"
module tb_charge_limit_bank;
  logic clock, rst_n, clk_en, pg, rd_valid, wr_strobe, rd_strobe, wr_busy, chg_en, ok;
  logic [1:0] cells;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data, cvl, cvc, ccs, rdv;
  int error_cnt = 0;
  int samples_checked = 0;
  // Strap defaults as words: the mV figure is the word since the LSB is 16 mV at bit 4
  logic [15:0] def_w [4] = '{16'(`CVL_DEF_1S_MV), 16'(`CVL_DEF_2S_MV), 16'(`CVL_DEF_3S_MV),
    16'(`CVL_DEF_4S_MV)};

  // Clock and pin values at time zero
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    clk_en = 1'b1;
    pg = 1'b1;
  end

  host_model u_host (.clock(clock), .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid));
  charge_limit_bank u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .cell_count_config_pin(cells),
    .input_power_good(pg), .cmd_code(cmd_code), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid), .wr_busy(wr_busy),
    .charge_voltage_limit(cvl), .charge_voltage_command(cvc), .charge_current_setting(ccs),
    .charge_enable(chg_en));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Reset for 16 cycles with a given strap, then wait for the default load
  task automatic do_reset(input logic [1:0] c);
    int n;
    rst_n = 1'b0;
    cells = c;
    repeat (16) @(negedge clock);
    chk({ccs[15:1], chg_en}, 16'h0000, "current at reset");
    rst_n = 1'b1;
    n = 0;
    while (wr_busy !== 1'b0 && n < 10) begin
      @(negedge clock);
      n++;
    end
    chk(16'(wr_busy), 16'h0000, "busy stuck");
    chk(16'(n), 16'h0003, "boot cycles");
  endtask
  // Every strap code loads its default, seen as target and read back
  task automatic t_defaults();
    for (int c = 0; c < 4; c++) begin
      do_reset(2'(c));
      chk(cvl, def_w[c], "default");
      chk(cvc, def_w[c], "target");
      u_host.rd(`CMD_CHARGE_VOLTAGE, rdv, ok);
      chk(rdv, def_w[c], "read default");
      chk(16'(ok), 16'h0001, "read default strobe");
      chk({ccs[15:1], chg_en}, 16'h0000, "no charge");
    end
  endtask
  // Reserved low bits dropped, read returns accepted word, unknown command silent
  task automatic t_write_read();
    u_host.wr(`CMD_CHARGE_VOLTAGE, 16'h20df);
    chk(cvl, 16'h20d0, "low bits");
    u_host.rd(`CMD_CHARGE_VOLTAGE, rdv, ok);
    chk(rdv, 16'h20d0, "read back");
    chk(16'(ok), 16'h0001, "read strobe");
    u_host.rd(8'h16, rdv, ok);
    chk(16'(ok), 16'h0000, "unknown cmd");
  endtask
  // Both range edges and the reserved top bit
  task automatic t_range();
    logic [15:0] w [5];
    logic acc [5];
    logic [15:0] exp;
    w = '{16'h03f0, 16'h0400, 16'h4b00, 16'h4b10, 16'h8400};
    acc = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    exp = cvl;
    for (int i = 0; i < 5; i++) begin
      u_host.wr(`CMD_CHARGE_VOLTAGE, w[i]);
      if (acc[i]) exp = w[i];
      chk(cvl, exp, "range");
      chk(cvc, exp, "range target");
    end
  endtask
  // Current first starts charging; zero voltage write restores default and stops it
  task automatic t_zero();
    u_host.wr(`CMD_CHARGE_CURRENT, 16'h0400);
    chk({ccs[15:1], chg_en}, 16'h0401, "charge start");
    u_host.wr(`CMD_CHARGE_VOLTAGE, 16'h0000);
    chk(cvl, def_w[cells], "zero default");
    chk({ccs[15:1], chg_en}, 16'h0000, "zero stops");
  endtask
  // Current word: code kept, reserved top bits refuse, read back; a low enable freezes all
  task automatic t_current();
    logic [15:0] held;
    u_host.wr(`CMD_CHARGE_CURRENT, 16'h1fff);
    chk(ccs, 16'h1fc0, "current word");
    chk(16'(chg_en), 16'h0001, "current start");
    u_host.wr(`CMD_CHARGE_CURRENT, 16'h2040);
    chk(ccs, 16'h1fc0, "current reserved");
    u_host.rd(`CMD_CHARGE_CURRENT, rdv, ok);
    chk(rdv, 16'h1fc0, "current read");
    chk(16'(ok), 16'h0001, "current read strobe");
    held = cvl;
    clk_en = 1'b0;
    u_host.wr(`CMD_CHARGE_VOLTAGE, 16'h0000);
    chk(cvl, held, "frozen voltage");
    chk(ccs, 16'h1fc0, "frozen current");
    clk_en = 1'b1;
  endtask
  // Voltage then current; losing power good ends charging and refuses new current
  task automatic t_order();
    u_host.setup(16'h3480, 16'h0040);
    chk(cvl, 16'h3480, "ordered volt");
    chk({ccs[15:1], chg_en}, 16'h0041, "ordered start");
    pg = 1'b0;
    repeat (6) @(negedge clock);
    chk({ccs[15:1], chg_en}, 16'h0000, "power lost");
    u_host.wr(`CMD_CHARGE_CURRENT, 16'h0040);
    chk({ccs[15:1], chg_en}, 16'h0000, "no power no charge");
  endtask
  // Writes made before the strap default is in are dropped
  task automatic t_busy();
    rst_n = 1'b0;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    u_host.wr(`CMD_CHARGE_VOLTAGE, 16'h0400);
    chk(16'(wr_busy), 16'h0001, "busy at boot");
    @(negedge clock);
    chk(cvl, def_w[cells], "boot write dropped");
    chk(16'(wr_busy), 16'h0000, "busy cleared");
  endtask

  // Main sequence
  initial begin
    t_defaults();
    t_write_read();
    t_range();
    t_zero();
    t_current();
    t_order();
    t_busy();
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100us;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
